// ### dcf_regs.svh
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

// Register byte offsets on the Avalon-MM slave.
`define DCF_REG_FLAGS 6'h00
`define DCF_REG_IRQ_STS 6'h04
`define DCF_REG_IRQ_MSK 6'h08
`define DCF_REG_EMPTY_OFS 6'h0C
`define DCF_REG_FULL_OFS 6'h10
`define DCF_REG_COUNT 6'h14

// Field positions of the flag and configuration register.
`define DCF_FLG_EMPTY 0
`define DCF_FLG_FULL 1
`define DCF_FLG_AE 2
`define DCF_FLG_AF 3
`define DCF_FLG_HF 4
`define DCF_FLG_FALL_THROUGH_MODE 5
`define DCF_FLG_SYNC 6
`define DCF_FLG_EF_LO 8
`define DCF_FLG_EF_HI 9
`define DCF_FLG_FF_LO 10
`define DCF_FLG_FF_HI 11

// Interrupt status and mask bit positions.
`define DCF_IRQ_WR_REFUSED 0
`define DCF_IRQ_RD_REFUSED 1
`define DCF_IRQ_FULL 2
`define DCF_IRQ_EMPTY 3
`define DCF_IRQ_W 4

// Reset values.
`define DCF_OFS_RESET 12'h01F
`define DCF_OFS_RESET_512 12'h03F
`define DCF_OFS_RESET_LARGE 12'h07F
`define DCF_MSK_RESET 4'h0
`define DCF_STS_RESET 4'h0

// Longest flag buffering chain.
`define DCF_PIPE_MAX 3

`endif

// ### dcf_pkg.sv
package dcf_pkg;

	// Timing mode chosen at reset.
	typedef enum logic {DCF_MODE_STD, DCF_MODE_FALL_THROUGH_MODE} dcf_mode_t;

	// Partial flag timing chosen at reset.
	typedef enum logic {DCF_PF_ASYNC, DCF_PF_SYNC} dcf_pf_t;

	// Number of register stages in a buffered flag.
	typedef logic [1:0] dcf_stages_t;

	// Avalon slave handshake states.
	typedef enum logic {DCF_BUS_IDLE, DCF_BUS_ANSWER} dcf_bus_t;

endpackage

// ### dcf_mem.sv
`timescale 1ns/10ps
module dcf_mem
	import dcf_pkg::*;
#(
	parameter int WIDTH = 18,
	parameter int DEPTH = 256,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	// The array has no reset so it can map onto block RAM.
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	// Output register starts at all zeros and holds between loads.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= '0;
		end else if (rd_en_i) begin
			rd_data_o <= mem_q[rd_addr_i];
		end
	end

endmodule // dcf_mem

// ### dcf_cfg_decode.sv
`timescale 1ns/10ps
module dcf_cfg_decode
	import dcf_pkg::*;
(
	input wire logic first_load_select_i,
	input wire logic read_chain_in_i,
	input wire logic write_chain_in_i,
	output dcf_mode_t mode_o,
	output dcf_pf_t partial_o,
	output dcf_stages_t ef_stages_o,
	output dcf_stages_t ff_stages_o
);

	// Strap decode; both chain inputs high overrides the first-load strap.
	always_comb begin
		mode_o = DCF_MODE_STD;
		partial_o = first_load_select_i ? DCF_PF_SYNC : DCF_PF_ASYNC;
		ef_stages_o = 2'h1;
		ff_stages_o = 2'h1;
		case ({read_chain_in_i, write_chain_in_i})
			2'h1: begin
				mode_o = DCF_MODE_FALL_THROUGH_MODE;
				ef_stages_o = 2'h3;
				ff_stages_o = 2'h2;
			end
			2'h2: begin
				ef_stages_o = 2'h2;
				ff_stages_o = 2'h2;
			end
			2'h3: begin
				partial_o = DCF_PF_ASYNC;
			end
			default: begin
				ef_stages_o = 2'h1;
			end
		endcase
	end

endmodule // dcf_cfg_decode

// ### dcf_top.sv
// Overview of operation
// - Fall-through empty: ready-in low, ready-out high, AF/HF high, AE low; full at depth+1.
// - Fall-through almost-empty low up to offset plus one, high from offset plus two.
// - Fall-through almost-full low from depth plus one minus full offset upward.
// - Fall-through half-full low from half depth plus two; ready-out low once stored.
// - Chain straps 0/1 select fall-through, triple output-ready, double input-ready.
// - Chain straps 1/0 select standard timing with double-buffered empty and full.
// - Chain straps 0/0 select standard timing with single-buffered empty and full.
// - First-load strap picks sync partial flags; both chain straps high forces async.
// - Sync partial flags: almost-empty moves on read ticks, almost-full on write ticks.
// - Async partial flags: assert on own side tick, release on the other side tick.
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "dcf_regs.svh"
module dcf_top
	import dcf_pkg::*;
#(
	parameter int WIDTH = 18,
	parameter int DEPTH = 256,
	parameter int OFS_W = 12
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic first_load_select_i,
	input wire logic read_chain_in_i,
	input wire logic write_chain_in_i,
	input wire logic wr_tick_i,
	input wire logic wr_en_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic rd_tick_i,
	input wire logic rd_en_i,
	output logic [WIDTH-1:0] rd_data_o,
	output logic empty_indicator_n_o,
	output logic full_indicator_n_o,
	output logic almost_empty_n_o,
	output logic almost_full_n_o,
	output logic half_full_n_o,
	output logic irq_o,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 2);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [15:0] DEPTH_W = 16'(DEPTH);
	localparam logic [15:0] HALF_W = 16'(DEPTH / 2);
	// Default offsets grow with depth; anything deeper than 512 takes the largest one.
	localparam logic [OFS_W-1:0] OFS_DEF = (DEPTH <= 256) ? OFS_W'(`DCF_OFS_RESET) :
		(DEPTH <= 512) ? OFS_W'(`DCF_OFS_RESET_512) : OFS_W'(`DCF_OFS_RESET_LARGE);

	logic rst_meta_q;
	logic rst_n;
	dcf_mode_t dec_mode;
	dcf_pf_t dec_partial;
	dcf_stages_t dec_ef;
	dcf_stages_t dec_ff;
	dcf_mode_t mode_q;
	dcf_pf_t partial_q;
	dcf_stages_t ef_stages_q;
	dcf_stages_t ff_stages_q;
	logic fall_through_mode;
	logic sync_pf;
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [CW-1:0] mem_cnt_q;
	logic [CW-1:0] mem_cnt_d;
	logic out_valid_q;
	logic out_valid_d;
	logic [CW-1:0] total_q;
	logic [CW-1:0] total_d;
	logic [CW-1:0] cap;
	logic wr_go;
	logic load;
	logic rd_req;
	logic [`DCF_PIPE_MAX-1:0] emp_pipe_q;
	logic [`DCF_PIPE_MAX-1:0] full_pipe_q;
	logic emp_buf;
	logic full_buf;
	logic [15:0] total_w;
	logic ae_low;
	logic af_low;
	logic hf_low;
	logic ae_q;
	logic af_q;
	logic hf_q;
	logic [OFS_W-1:0] empty_ofs_q;
	logic [OFS_W-1:0] full_ofs_q;
	logic [`DCF_IRQ_W-1:0] sts_q;
	logic [`DCF_IRQ_W-1:0] msk_q;
	logic [`DCF_IRQ_W-1:0] sts_set;
	logic [`DCF_IRQ_W-1:0] sts_clr;
	dcf_bus_t bus_q;
	logic acc_wr;
	logic [31:0] rd_mux;

	// Reset is asserted at once but released through two flops.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	dcf_cfg_decode u_cfg (
		.first_load_select_i(first_load_select_i),
		.read_chain_in_i(read_chain_in_i),
		.write_chain_in_i(write_chain_in_i),
		.mode_o(dec_mode),
		.partial_o(dec_partial),
		.ef_stages_o(dec_ef),
		.ff_stages_o(dec_ff)
	);

	// Straps are sampled on every edge while reset is held and then frozen.
	// A clocked capture avoids loading a port value under asynchronous reset.
	always_ff @(posedge clk_i) begin
		if (!rst_n) begin
			mode_q <= dec_mode;
			partial_q <= dec_partial;
			ef_stages_q <= dec_ef;
			ff_stages_q <= dec_ff;
		end
	end

	assign fall_through_mode = (mode_q == DCF_MODE_FALL_THROUGH_MODE);
	assign sync_pf = (partial_q == DCF_PF_SYNC);

	// Write and read acceptance; the fall-through output word is self-loaded.
	assign wr_go = wr_tick_i && wr_en_i && (mem_cnt_q != DEPTH_C);
	assign rd_req = rd_tick_i && rd_en_i;
	assign load = rd_tick_i && (mem_cnt_q != '0) && (fall_through_mode ? (!out_valid_q || rd_en_i) : rd_en_i);

	// Next occupancy; in fall-through the output register adds one word.
	always_comb begin
		mem_cnt_d = mem_cnt_q;
		if (wr_go && !load) begin
			mem_cnt_d = mem_cnt_q + CW'(1);
		end else if (!wr_go && load) begin
			mem_cnt_d = mem_cnt_q - CW'(1);
		end
		out_valid_d = out_valid_q;
		if (!fall_through_mode) begin
			out_valid_d = 1'b0;
		end else if (load) begin
			out_valid_d = 1'b1;
		end else if (rd_req) begin
			out_valid_d = 1'b0;
		end
		total_d = mem_cnt_d + CW'(fall_through_mode && out_valid_d);
		total_q = mem_cnt_q + CW'(fall_through_mode && out_valid_q);
		cap = DEPTH_C + CW'(fall_through_mode);
	end

	// Pointers and counts; depth must be a power of two for natural wrap.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
			mem_cnt_q <= '0;
			out_valid_q <= 1'b0;
		end else begin
			if (wr_go) begin
				wptr_q <= wptr_q + AW'(1);
			end
			if (load) begin
				rptr_q <= rptr_q + AW'(1);
			end
			mem_cnt_q <= mem_cnt_d;
			out_valid_q <= out_valid_d;
		end
	end

	dcf_mem #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_mem (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.wr_en_i(wr_go),
		.wr_addr_i(wptr_q),
		.wr_data_i(wr_data_i),
		.rd_en_i(load),
		.rd_addr_i(rptr_q),
		.rd_data_o(rd_data_o)
	);

	// Boundary flags pass through register chains on their own side's tick.
	// Deeper chains cost latency but keep boundary states clean.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			emp_pipe_q <= '1;
		end else if (rd_tick_i) begin
			emp_pipe_q <= {emp_pipe_q[`DCF_PIPE_MAX-2:0], (total_d == '0)};
		end
	end

	// Full side chain on the write tick.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			full_pipe_q <= '0;
		end else if (wr_tick_i) begin
			full_pipe_q <= {full_pipe_q[`DCF_PIPE_MAX-2:0], (total_d == cap)};
		end
	end

	assign emp_buf = emp_pipe_q[ef_stages_q - 2'h1];
	assign full_buf = full_pipe_q[ff_stages_q - 2'h1];

	// Output-ready is high when empty; empty flag is low when empty.
	assign empty_indicator_n_o = fall_through_mode ? emp_buf : !emp_buf;
	assign full_indicator_n_o = fall_through_mode ? full_buf : !full_buf;

	// Partial flag thresholds; fall-through shifts each by one word.
	always_comb begin
		total_w = 16'(total_d);
		ae_low = total_w <= (16'(empty_ofs_q) + 16'(fall_through_mode));
		af_low = (total_w + 16'(full_ofs_q)) >= (DEPTH_W + 16'(fall_through_mode));
		hf_low = total_w >= (HALF_W + 16'h0001 + 16'(fall_through_mode));
	end

	// Almost-empty: sync moves on read ticks, async releases on write ticks.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ae_q <= 1'b0;
		end else if (sync_pf) begin
			if (rd_tick_i) begin
				ae_q <= !ae_low;
			end
		end else if (rd_tick_i && ae_low) begin
			ae_q <= 1'b0;
		end else if (wr_tick_i && !ae_low) begin
			ae_q <= 1'b1;
		end
	end

	// Almost-full: the mirror image of almost-empty.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			af_q <= 1'b1;
		end else if (sync_pf) begin
			if (wr_tick_i) begin
				af_q <= !af_low;
			end
		end else if (wr_tick_i && af_low) begin
			af_q <= 1'b0;
		end else if (rd_tick_i && !af_low) begin
			af_q <= 1'b1;
		end
	end

	// Half-full follows the count on every cycle.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hf_q <= 1'b1;
		end else begin
			hf_q <= !hf_low;
		end
	end

	assign almost_empty_n_o = ae_q;
	assign almost_full_n_o = af_q;
	assign half_full_n_o = hf_q;

	// Avalon handshake: one wait state, answer on the second cycle.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			bus_q <= DCF_BUS_IDLE;
		end else begin
			case (bus_q)
				DCF_BUS_IDLE: begin
					if (avs_read_i || avs_write_i) begin
						bus_q <= DCF_BUS_ANSWER;
					end
				end
				default: begin
					bus_q <= DCF_BUS_IDLE;
				end
			endcase
		end
	end

	assign avs_waitrequest_o = (bus_q != DCF_BUS_ANSWER);
	assign acc_wr = (bus_q == DCF_BUS_ANSWER) && avs_write_i;

	// Read mux; unmapped addresses read as zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (avs_address_i == `DCF_REG_FLAGS) begin
			rd_mux[`DCF_FLG_EMPTY] = empty_indicator_n_o;
			rd_mux[`DCF_FLG_FULL] = full_indicator_n_o;
			rd_mux[`DCF_FLG_AE] = ae_q;
			rd_mux[`DCF_FLG_AF] = af_q;
			rd_mux[`DCF_FLG_HF] = hf_q;
			rd_mux[`DCF_FLG_FALL_THROUGH_MODE] = fall_through_mode;
			rd_mux[`DCF_FLG_SYNC] = sync_pf;
			rd_mux[`DCF_FLG_EF_HI:`DCF_FLG_EF_LO] = ef_stages_q;
			rd_mux[`DCF_FLG_FF_HI:`DCF_FLG_FF_LO] = ff_stages_q;
		end else if (avs_address_i == `DCF_REG_IRQ_STS) begin
			rd_mux[`DCF_IRQ_W-1:0] = sts_q;
		end else if (avs_address_i == `DCF_REG_IRQ_MSK) begin
			rd_mux[`DCF_IRQ_W-1:0] = msk_q;
		end else if (avs_address_i == `DCF_REG_EMPTY_OFS) begin
			rd_mux[OFS_W-1:0] = empty_ofs_q;
		end else if (avs_address_i == `DCF_REG_FULL_OFS) begin
			rd_mux[OFS_W-1:0] = full_ofs_q;
		end else if (avs_address_i == `DCF_REG_COUNT) begin
			rd_mux[CW-1:0] = total_q;
		end
	end

	// Read data are caught in the wait cycle and stand through the answer.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (bus_q == DCF_BUS_IDLE && avs_read_i) begin
			avs_readdata_o <= rd_mux;
		end
	end

	// Offsets and mask take effect at the answer edge, honouring byte enables.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			empty_ofs_q <= OFS_DEF;
			full_ofs_q <= OFS_DEF;
			msk_q <= `DCF_MSK_RESET;
		end else if (acc_wr) begin
			if (avs_address_i == `DCF_REG_EMPTY_OFS) begin
				if (avs_byteenable_i[0]) empty_ofs_q[7:0] <= avs_writedata_i[7:0];
				if (avs_byteenable_i[1]) empty_ofs_q[OFS_W-1:8] <= avs_writedata_i[OFS_W-1:8];
			end else if (avs_address_i == `DCF_REG_FULL_OFS) begin
				if (avs_byteenable_i[0]) full_ofs_q[7:0] <= avs_writedata_i[7:0];
				if (avs_byteenable_i[1]) full_ofs_q[OFS_W-1:8] <= avs_writedata_i[OFS_W-1:8];
			end else if (avs_address_i == `DCF_REG_IRQ_MSK && avs_byteenable_i[0]) begin
				msk_q <= avs_writedata_i[`DCF_IRQ_W-1:0];
			end
		end
	end

	// Events that set sticky status bits.
	always_comb begin
		sts_set[`DCF_IRQ_WR_REFUSED] = wr_tick_i && wr_en_i && !wr_go;
		sts_set[`DCF_IRQ_RD_REFUSED] = rd_req && (fall_through_mode ? !out_valid_q : (mem_cnt_q == '0));
		sts_set[`DCF_IRQ_FULL] = (total_d == cap) && (total_q != cap);
		sts_set[`DCF_IRQ_EMPTY] = (total_d == '0) && (total_q != '0);
		sts_clr = '0;
		if (acc_wr && avs_address_i == `DCF_REG_IRQ_STS && avs_byteenable_i[0]) begin
			sts_clr = avs_writedata_i[`DCF_IRQ_W-1:0];
		end
	end

	// One sticky bit per event; a new event wins over a same-cycle clear.
	for (genvar i = 0; i < `DCF_IRQ_W; i++) begin : g_sts
		always_ff @(posedge clk_i or negedge rst_n) begin
			if (!rst_n) begin
				sts_q[i] <= 1'b0;
			end else begin
				sts_q[i] <= sts_set[i] || (sts_q[i] && !sts_clr[i]);
			end
		end
	end

	assign irq_o = |(sts_q & msk_q);

	// Checks.
	sequence s_bus_req;
		(avs_read_i || avs_write_i) && (bus_q == DCF_BUS_IDLE);
	endsequence

	sequence s_fall_through_mode_release;
		$rose(rst_n) && fall_through_mode;
	endsequence

	AST_FALL_THROUGH_MODE_EMPTY_FLAGS: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_fall_through_mode_release |-> empty_indicator_n_o && !full_indicator_n_o && almost_full_n_o
		&& half_full_n_o && !almost_empty_n_o)
		else $error("Fall-through flags wrong after reset.");

	AST_FALL_THROUGH_MODE_AE_SYNC: assert property (@(posedge clk_i) disable iff (!rst_n)
		fall_through_mode && sync_pf && rd_tick_i && (16'(total_d) <= 16'(empty_ofs_q) + 16'h0001)
		|=> !almost_empty_n_o)
		else $error("Almost-empty not low at or below offset plus one.");

	AST_FALL_THROUGH_MODE_AF_SYNC: assert property (@(posedge clk_i) disable iff (!rst_n)
		fall_through_mode && sync_pf && wr_tick_i && (16'(total_d) + 16'(full_ofs_q) >= DEPTH_W + 16'h0001)
		|=> !almost_full_n_o)
		else $error("Almost-full not low at depth plus one minus offset.");

	AST_FALL_THROUGH_MODE_HALF: assert property (@(posedge clk_i) disable iff (!rst_n)
		fall_through_mode && !$rose(rst_n) |-> half_full_n_o == (16'(total_q) < HALF_W + 16'h0002))
		else $error("Half-full threshold wrong in fall-through.");

	AST_FALL_THROUGH_MODE_STRAPS: assert property (@(posedge clk_i) disable iff (!rst_n)
		$rose(rst_n) |-> (fall_through_mode == $past(!read_chain_in_i && write_chain_in_i)))
		else $error("Fall-through mode not decoded from chain straps.");

	AST_FALL_THROUGH_MODE_BUFFERS: assert property (@(posedge clk_i) disable iff (!rst_n)
		fall_through_mode |-> (ef_stages_q == 2'h3) && (ff_stages_q == 2'h2))
		else $error("Fall-through buffering not triple and double.");

	AST_STD_DOUBLE: assert property (@(posedge clk_i) disable iff (!rst_n)
		$rose(rst_n) && $past(read_chain_in_i && !write_chain_in_i)
		|-> !fall_through_mode && (ef_stages_q == 2'h2) && (ff_stages_q == 2'h2))
		else $error("Double buffering not selected.");

	AST_STD_SINGLE: assert property (@(posedge clk_i) disable iff (!rst_n)
		$rose(rst_n) && $past(!read_chain_in_i && !write_chain_in_i)
		|-> !fall_through_mode && (ef_stages_q == 2'h1) && (ff_stages_q == 2'h1))
		else $error("Single buffering not selected.");

	AST_PARTIAL_SEL: assert property (@(posedge clk_i) disable iff (!rst_n)
		$rose(rst_n) |-> sync_pf == $past(first_load_select_i
		&& !(read_chain_in_i && write_chain_in_i)))
		else $error("Partial flag timing strap decoded wrongly.");

	AST_SYNC_AE_EDGE: assert property (@(posedge clk_i) disable iff (!rst_n)
		sync_pf && !$rose(rst_n) && $changed(almost_empty_n_o) |-> $past(rd_tick_i))
		else $error("Sync almost-empty moved without a read tick.");

	AST_ASYNC_AE_RELEASE: assert property (@(posedge clk_i) disable iff (!rst_n)
		!sync_pf && !$rose(rst_n) && $rose(almost_empty_n_o) |-> $past(wr_tick_i))
		else $error("Async almost-empty released without a write tick.");

	AST_MODE_HELD: assert property (@(posedge clk_i) disable iff (!rst_n)
		!$rose(rst_n) |-> $stable(mode_q) && $stable(partial_q))
		else $error("Configuration changed outside reset.");

	AST_BUS_ANSWER: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_bus_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("Bus answer not given in the second cycle.");

endmodule // dcf_top

// ### dcf_stream_model.sv
`timescale 1ns/10ps
module dcf_stream_model #(
	parameter int WIDTH = 18
) (
	input wire logic clk_i,
	output logic wr_tick_o,
	output logic wr_en_o,
	output logic [WIDTH-1:0] wr_data_o,
	output logic rd_tick_o,
	output logic rd_en_o
);
	// Both sides start quiet so no tick is seen before the first step.
	initial begin
		wr_tick_o = 1'b0;
		wr_en_o = 1'b0;
		wr_data_o = '0;
		rd_tick_o = 1'b0;
		rd_en_o = 1'b0;
	end

	// One step lasts one cycle; the following step replaces it at the next edge.
	task automatic step(input logic wt, input logic we, input logic rt, input logic re,
		input logic [WIDTH-1:0] d);
		@(posedge clk_i);
		wr_tick_o <= wt;
		wr_en_o <= we;
		rd_tick_o <= rt;
		rd_en_o <= re;
		// An idle data bus shows the inverse of its last word, so stale data cannot pass.
		wr_data_o <= we ? d : ~wr_data_o;
	endtask
endmodule // dcf_stream_model

// ### dcf_top_bench.sv
`timescale 1ns/10ps
`include "dcf_regs.svh"
module dcf_top_bench;
	import dcf_pkg::*;
	localparam int DEPTH = 16;
	localparam int N_OFS = 3;
	localparam int M_OFS = 3;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic first_load_select = 1'b0;
	logic read_chain_in = 1'b0;
	logic write_chain_in = 1'b1;
	logic wr_tick, wr_en, rd_tick, rd_en;
	logic [17:0] wr_data, rd_data;
	logic empty_ind_n, full_ind_n, ae_n, af_n, hf_n, irq;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, q;
	logic avs_waitrequest;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;

	dcf_top #(.WIDTH(18), .DEPTH(DEPTH), .OFS_W(12)) uut (.clk_i(clk), .rst_b_i(rst_b),
		.first_load_select_i(first_load_select), .read_chain_in_i(read_chain_in),
		.write_chain_in_i(write_chain_in), .wr_tick_i(wr_tick), .wr_en_i(wr_en),
		.wr_data_i(wr_data), .rd_tick_i(rd_tick), .rd_en_i(rd_en), .rd_data_o(rd_data),
		.empty_indicator_n_o(empty_ind_n), .full_indicator_n_o(full_ind_n),
		.almost_empty_n_o(ae_n), .almost_full_n_o(af_n), .half_full_n_o(hf_n), .irq_o(irq),
		.avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
		.avs_writedata_i(avs_writedata), .avs_byteenable_i(4'hF),
		.avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest));

	dcf_stream_model #(.WIDTH(18)) ptn (.clk_i(clk), .wr_tick_o(wr_tick), .wr_en_o(wr_en),
		.wr_data_o(wr_data), .rd_tick_o(rd_tick), .rd_en_o(rd_en));

	// Free-running 10 MHz clock.
	always #50 clk = ~clk;

	// A hung wait counts as a mismatch and still ends in the closing report.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic complete_run;
		if (err_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One Avalon access; the request is held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Straps are held stable across the whole reset so every capture edge sees them.
	task automatic reset_with(input logic fl, input logic rx, input logic wx);
		@(posedge clk);
		rst_b <= 1'b0;
		first_load_select <= fl;
		read_chain_in <= rx;
		write_chain_in <= wx;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	task automatic set_offsets;
		bus(1'b1, `DCF_REG_EMPTY_OFS, N_OFS, q);
		bus(1'b1, `DCF_REG_FULL_OFS, M_OFS, q);
		bus(1'b1, `DCF_REG_IRQ_STS, 32'hF, q);
	endtask

	// Three ticks on each side let both flag chains reach their taps.
	task automatic settle;
		repeat (3) ptn.step(1'b1, 1'b0, 1'b1, 1'b0, 18'h0);
		ptn.step(1'b0, 1'b0, 1'b0, 1'b0, 18'h0);
		@(posedge clk);
	endtask

	function automatic logic [17:0] word(input int j);
		return 18'(j * 7 + 'h155);
	endfunction

	task automatic chk_lvl(input int k);
		chk("in_rdy_n", full_ind_n, k == DEPTH + 1);
		chk("ae_n", ae_n, !(k <= N_OFS + 1));
		chk("af_n", af_n, !(k + M_OFS >= DEPTH + 1));
		chk("hf_n", hf_n, !(k >= DEPTH / 2 + 2));
		chk("out_rdy_n", empty_ind_n, k == 0);
		bus(1'b0, `DCF_REG_COUNT, 32'h0, q);
		chk("count", q, k);
	endtask

	// Partial flag moves for writes alone, then one read tick, then one true read.
	task automatic partial_timing(input logic fl);
		reset_with(fl, 1'b0, 1'b1);
		set_offsets();
		for (int j = 1; j <= N_OFS + 2; j++) ptn.step(1'b1, 1'b1, 1'b0, 1'b0, word(j));
		ptn.step(1'b0, 1'b0, 1'b0, 1'b0, 18'h0);
		@(posedge clk);
		chk("ae_n writes only", ae_n, !fl);
		ptn.step(1'b0, 1'b0, 1'b1, 1'b0, 18'h0);
		ptn.step(1'b0, 1'b0, 1'b1, 1'b1, 18'h0);
		ptn.step(1'b0, 1'b0, 1'b0, 1'b0, 18'h0);
		@(posedge clk);
		chk("ae_n after read", ae_n, 1'b0);
	endtask

	// One stored word: the empty or output-ready flag moves after the chain's count of read ticks.
	task automatic ef_latency(input logic rx, input logic wx, input int n);
		reset_with(1'b0, rx, wx);
		ptn.step(1'b1, 1'b1, 1'b0, 1'b0, word(1));
		for (int t = 1; t <= n; t++) begin
			ptn.step(1'b0, 1'b0, 1'b1, 1'b0, 18'h0);
			ptn.step(1'b0, 1'b0, 1'b0, 1'b0, 18'h0);
			@(posedge clk);
			chk("ef latency", empty_ind_n, (t == n) ^ (wx && !rx));
		end
		chk("fall-through data", rd_data, (wx && !rx) ? word(1) : 18'h0);
		ptn.step(1'b0, 1'b0, 1'b1, 1'b1, 18'h0);
		ptn.step(1'b0, 1'b0, 1'b0, 1'b0, 18'h0);
		@(posedge clk);
		chk("read data", rd_data, word(1));
	endtask

	initial begin
		logic fw, sy;
		logic [1:0] ef, ff;
		// Every strap combination, with register reset values and strap hold checked.
		for (int i = 0; i < 8; i++) begin
			reset_with(i[2], i[1], i[0]);
			fw = !i[1] && i[0];
			sy = i[2] && !(i[1] && i[0]);
			ef = fw ? 2'd3 : (i[1] && !i[0]) ? 2'd2 : 2'd1;
			ff = (fw || (i[1] && !i[0])) ? 2'd2 : 2'd1;
			chk("out_rdy_n reset", empty_ind_n, fw);
			bus(1'b0, `DCF_REG_FLAGS, 32'h0, q);
			chk("flags", q & 32'hF7F, {ff, ef, 1'b0, sy, fw, 3'b110, !fw, fw});
			first_load_select <= !i[2];
			read_chain_in <= !i[1];
			write_chain_in <= !i[0];
			bus(1'b0, `DCF_REG_FLAGS, 32'h0, q);
			chk("flags held", q & 32'hF7F, {ff, ef, 1'b0, sy, fw, 3'b110, !fw, fw});
			bus(1'b0, `DCF_REG_EMPTY_OFS, 32'h0, q);
			chk("empty ofs reset", q, 32'd31);
			bus(1'b0, `DCF_REG_FULL_OFS, 32'h0, q);
			chk("full ofs reset", q, 32'd31);
			bus(1'b0, `DCF_REG_IRQ_MSK, 32'h0, q);
			chk("mask reset", q, 32'h0);
		end
		// Fill to depth plus one and past it in synchronous fall-through mode.
		reset_with(1'b1, 1'b0, 1'b1);
		set_offsets();
		chk_lvl(0);
		for (int k = 1; k <= DEPTH + 2; k++) begin
			ptn.step(1'b1, 1'b1, 1'b0, 1'b0, word(k));
			settle();
			chk_lvl(k > DEPTH + 1 ? DEPTH + 1 : k);
		end
		bus(1'b0, `DCF_REG_IRQ_STS, 32'h0, q);
		chk("sts full", q, 32'h5);
		chk("irq masked", irq, 1'b0);
		bus(1'b1, `DCF_REG_IRQ_STS, 32'hF, q);
		// Drain in order, then read once more while empty.
		for (int k = DEPTH + 1; k >= 0; k--) begin
			if (k > 0) chk("rd_data", rd_data, word(DEPTH + 2 - k));
			ptn.step(1'b0, 1'b0, 1'b1, 1'b1, 18'h0);
			settle();
			chk_lvl(k > 0 ? k - 1 : 0);
		end
		bus(1'b0, `DCF_REG_IRQ_STS, 32'h0, q);
		chk("sts empty", q, 32'hA);
		bus(1'b1, `DCF_REG_IRQ_MSK, 32'h2, q);
		@(posedge clk);
		chk("irq on", irq, 1'b1);
		bus(1'b1, `DCF_REG_IRQ_STS, 32'h2, q);
		@(posedge clk);
		chk("irq cleared", irq, 1'b0);
		bus(1'b0, `DCF_REG_IRQ_STS, 32'h0, q);
		chk("sts w1c", q, 32'h8);
		bus(1'b0, 6'h3C, 32'h0, q);
		chk("unmapped", q, 32'h0);
		ef_latency(1'b0, 1'b0, 1);
		ef_latency(1'b1, 1'b0, 2);
		ef_latency(1'b0, 1'b1, 3);
		partial_timing(1'b1);
		partial_timing(1'b0);
		complete_run();
	end
endmodule // dcf_top_bench
